// >>> verilog/ctpwm_timer.sv
`timescale 1ns/1ns
`include "ctpwm_defs.svh"

module ctpwm_timer
  import ctpwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire ctpwm_req_t bus_req,
  output logic [7:0] rdata,
  output ctpwm_pin_t timer_pin,
  output logic irq
);

  logic [7:0] ctrl0;
  ctpwm_ctrl_t ctrl;
  logic [9:0] compare_reg_a;
  logic [9:0] cnt;
  logic [6:0] presc;
  logic [1:0] status;
  logic [1:0] mask;
  logic run_d;
  logic cmp_state;

  logic timer_run;
  logic [2:0] compare_reg_p;
  logic [2:0] div_sel;
  logic run_rise;
  logic tick;
  logic [10:0] nxt;
  logic a_match;
  logic p_match;
  logic pwm_mode;
  logic [10:0] period;
  logic [10:0] duty;
  logic clr;
  logic set_a;
  logic set_p;
  logic pwm_active;
  logic [1:0] w1c;
  logic [1:0] next_status;
  ctpwm_pin_t next_pin;

  // Compare register P scaled to counter units; zero means a full 1024 count
  function automatic logic [10:0] cmpp_target(input logic [2:0] v);
    cmpp_target = (v == 3'h0) ? `CTPWM_CNT_FULL : 11'({v, 7'h00});
  endfunction

  // Compare register A as a period; zero means a full 1024 count
  function automatic logic [10:0] cmpa_target(input logic [9:0] v);
    cmpa_target = (v == 10'h000) ? `CTPWM_CNT_FULL : {1'b0, v};
  endfunction

  // Prescaler mask: a tick every 2^sel clocks
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    div_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  assign timer_run = ctrl0[`CTPWM_RUN_BIT];
  assign compare_reg_p = ctrl0[`CTPWM_CMPP_MSB:`CTPWM_CMPP_LSB];
  assign div_sel = ctrl0[`CTPWM_DIV_MSB:`CTPWM_DIV_LSB];

  // Register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl0 <= `CTPWM_RST_BYTE;
      ctrl <= ctpwm_ctrl_t'(`CTPWM_RST_BYTE);
      compare_reg_a <= `CTPWM_RST_CNT;
      mask <= `CTPWM_RST_FLAGS;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        `CTPWM_ADDR_CTRL0: ctrl0 <= bus_req.wdata;
        `CTPWM_ADDR_CTRL1: ctrl <= ctpwm_ctrl_t'(bus_req.wdata);
        `CTPWM_ADDR_CMPA_LO: compare_reg_a[7:0] <= bus_req.wdata;
        `CTPWM_ADDR_CMPA_HI: compare_reg_a[9:8] <= bus_req.wdata[1:0];
        `CTPWM_ADDR_MASK: mask <= bus_req.wdata[1:0];
        default: ;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= `CTPWM_RST_BYTE;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `CTPWM_ADDR_CTRL0: rdata <= ctrl0;
        `CTPWM_ADDR_CTRL1: rdata <= ctrl;
        `CTPWM_ADDR_CNT_LO: rdata <= cnt[7:0];
        `CTPWM_ADDR_CNT_HI: rdata <= {6'h00, cnt[9:8]};
        `CTPWM_ADDR_CMPA_LO: rdata <= compare_reg_a[7:0];
        `CTPWM_ADDR_CMPA_HI: rdata <= {6'h00, compare_reg_a[9:8]};
        `CTPWM_ADDR_STATUS: rdata <= {6'h00, status};
        `CTPWM_ADDR_MASK: rdata <= {6'h00, mask};
        default: rdata <= `CTPWM_RST_BYTE;
      endcase
    end else begin
      rdata <= `CTPWM_RST_BYTE;
    end
  end

  // Run edge and timer clock prescaler
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_d <= 1'b0;
    end else begin
      run_d <= timer_run;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      presc <= `CTPWM_RST_PRESC;
    end else if (!timer_run || run_rise) begin
      presc <= `CTPWM_RST_PRESC;
    end else begin
      presc <= presc + 7'h01;
    end
  end

  assign run_rise = timer_run && !run_d;
  assign tick = timer_run && !run_rise && ((presc & div_mask(div_sel)) == div_mask(div_sel));

  // Match and clear comparators look at the value the counter is about to take
  always_comb begin
    pwm_mode = ctrl.mode_select == `CTPWM_MODE_PWM;
    nxt = {1'b0, cnt} + `CTPWM_CNT_ONE;
    a_match = tick && compare_reg_a != 10'h000 && nxt == {1'b0, compare_reg_a};
    p_match = tick && nxt == cmpp_target(compare_reg_p);
    if (ctrl.period_duty_swap) begin
      period = cmpa_target(compare_reg_a);
      duty = cmpp_target(compare_reg_p);
    end else begin
      period = cmpp_target(compare_reg_p);
      duty = {1'b0, compare_reg_a};
    end
    if (pwm_mode) begin
      clr = tick && nxt == period;
    end else if (ctrl.clear_source_select) begin
      clr = a_match || (tick && nxt == `CTPWM_CNT_FULL);
    end else begin
      clr = p_match;
    end
    set_a = a_match;
    set_p = p_match && (pwm_mode || !ctrl.clear_source_select);
    pwm_active = (duty >= period) || ({1'b0, cnt} < duty);
  end

  // Counter keeps running whatever the pin shows
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= `CTPWM_RST_CNT;
    end else if (!timer_run || run_rise) begin
      cnt <= `CTPWM_RST_CNT;
    end else if (tick) begin
      cnt <= clr ? `CTPWM_RST_CNT : nxt[9:0];
    end
  end

  // Interrupt flags: set wins over a simultaneous write-one-to-clear
  always_comb begin
    w1c = (bus_req.wr && bus_req.addr == `CTPWM_ADDR_STATUS) ? bus_req.wdata[1:0] : 2'h0;
    next_status = status & ~w1c;
    next_status[`CTPWM_FLAG_A] = next_status[`CTPWM_FLAG_A] | set_a;
    next_status[`CTPWM_FLAG_P] = next_status[`CTPWM_FLAG_P] | set_p;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= `CTPWM_RST_FLAGS;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Compare-mode output state; initial level reloads on each run rising edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp_state <= 1'b0;
    end else if (run_rise) begin
      cmp_state <= ctrl.output_level_select;
    end else if (ctrl.mode_select == `CTPWM_MODE_CMP && a_match) begin
      case (ctrl.output_function)
        `CTPWM_FN_LOW: cmp_state <= 1'b0;
        `CTPWM_FN_HIGH: cmp_state <= 1'b1;
        `CTPWM_FN_TOGGLE: cmp_state <= !cmp_state;
        default: cmp_state <= cmp_state;
      endcase
    end
  end

  // Pin; PWM waveform stopped shows the inactive level so a restart begins clean
  always_comb begin
    next_pin.level = 1'b0;
    next_pin.oe_n = 1'b1;
    case (ctrl.mode_select)
      `CTPWM_MODE_CMP: begin
        next_pin.level = cmp_state ^ ctrl.output_invert;
        next_pin.oe_n = 1'b0;
      end
      `CTPWM_MODE_PWM: begin
        next_pin.oe_n = 1'b0;
        case (ctrl.output_function)
          `CTPWM_FN_FORCE_LO: next_pin.level = 1'b0;
          `CTPWM_FN_FORCE_HI: next_pin.level = 1'b1;
          default: begin
            if (timer_run && !run_rise && pwm_active) begin
              next_pin.level = ctrl.output_level_select ^ ctrl.output_invert;
            end else begin
              next_pin.level = !ctrl.output_level_select ^ ctrl.output_invert;
            end
          end
        endcase
      end
      default: begin
        next_pin.level = 1'b0;
        next_pin.oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_pin <= '{level: 1'b0, oe_n: 1'b1};
    end else begin
      timer_pin <= next_pin;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_tmr_pin_free;
    ctrl.mode_select == `CTPWM_MODE_TMR |=> timer_pin.oe_n;
  endproperty
  a_tmr_pin_free: assert property (p_tmr_pin_free) else $error("pin driven in timer mode");

  property p_tmr_flag;
    ctrl.mode_select == `CTPWM_MODE_TMR && tick && compare_reg_a != 10'h000 && nxt == {1'b0, compare_reg_a}
      |=> status[`CTPWM_FLAG_A];
  endproperty
  a_tmr_flag: assert property (p_tmr_flag) else $error("timer mode A match without flag");

  property p_pwm_force_hi;
    pwm_mode && ctrl.output_function == `CTPWM_FN_FORCE_HI |=> timer_pin.level && !timer_pin.oe_n;
  endproperty
  a_pwm_force_hi: assert property (p_pwm_force_hi) else $error("forced high not seen");

  property p_pwm_clear_p;
    pwm_mode && !ctrl.period_duty_swap && tick && nxt == cmpp_target(compare_reg_p) |=> cnt == `CTPWM_RST_CNT;
  endproperty
  a_pwm_clear_p: assert property (p_pwm_clear_p) else $error("P period clear missed");

  property p_pwm_clear_a;
    pwm_mode && ctrl.period_duty_swap && tick && nxt == cmpa_target(compare_reg_a) |=> cnt == `CTPWM_RST_CNT;
  endproperty
  a_pwm_clear_a: assert property (p_pwm_clear_a) else $error("A period clear missed");

  property p_pwm_flag_p;
    pwm_mode && tick && nxt == cmpp_target(compare_reg_p) |=> status[`CTPWM_FLAG_P];
  endproperty
  a_pwm_flag_p: assert property (p_pwm_flag_p) else $error("PWM P flag missed");

  property p_invert;
    pwm_mode && ctrl.output_function[1] && timer_run && !run_rise && pwm_active
      |=> timer_pin.level == ($past(ctrl.output_level_select) ^ $past(ctrl.output_invert));
  endproperty
  a_invert: assert property (p_invert) else $error("PWM active level wrong");

  property p_full_duty;
    pwm_mode && ctrl.output_function[1] && timer_run && !run_rise && duty >= period
      |=> timer_pin.level == ($past(ctrl.output_level_select) ^ $past(ctrl.output_invert));
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty not active");

  property p_p_no_pin;
    ctrl.mode_select == `CTPWM_MODE_CMP && !a_match && !run_rise |=> $stable(cmp_state);
  endproperty
  a_p_no_pin: assert property (p_p_no_pin) else $error("pin moved without A match");

  property p_run_init;
    run_rise |=> cmp_state == $past(ctrl.output_level_select);
  endproperty
  a_run_init: assert property (p_run_init) else $error("initial level not loaded");

  property p_no_p_flag;
    !pwm_mode && ctrl.clear_source_select && !status[`CTPWM_FLAG_P] |=> !status[`CTPWM_FLAG_P];
  endproperty
  a_no_p_flag: assert property (p_no_p_flag) else $error("P flag raised with clear on A");

  property p_overflow;
    !pwm_mode && ctrl.clear_source_select && compare_reg_a == 10'h000 && tick && cnt == `CTPWM_CNT_MAX
      |=> cnt == `CTPWM_RST_CNT;
  endproperty
  a_overflow: assert property (p_overflow) else $error("no overflow at top");

  property p_stop_clear;
    !timer_run |=> cnt == `CTPWM_RST_CNT ##1 cnt == `CTPWM_RST_CNT || $past(timer_run);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("counter not cleared when stopped");

  property p_irq;
    |(status & mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  // Idle part of the period must show the opposite level, or any duty would read as full
  property p_pwm_idle;
    pwm_mode && ctrl.output_function[1] && timer_run && !run_rise && duty < period && {1'b0, cnt} >= duty
      |=> timer_pin.level != ($past(ctrl.output_level_select) ^ $past(ctrl.output_invert));
  endproperty
  a_pwm_idle: assert property (p_pwm_idle) else $error("PWM inactive level wrong");

  property p_pwm_flag_a;
    pwm_mode && a_match |=> status[`CTPWM_FLAG_A];
  endproperty
  a_pwm_flag_a: assert property (p_pwm_flag_a) else $error("PWM A flag missed");

  // Forced levels hide the waveform only; the counter must still advance
  property p_forced_counts;
    pwm_mode && !ctrl.output_function[1] && tick && !clr |=> cnt == $past(cnt) + 10'h001;
  endproperty
  a_forced_counts: assert property (p_forced_counts) else $error("counter stalled while pin forced");

  property p_clear_on_a;
    !pwm_mode && ctrl.clear_source_select && a_match |=> cnt == `CTPWM_RST_CNT;
  endproperty
  a_clear_on_a: assert property (p_clear_on_a) else $error("A match did not clear counter");

  property p_cmp_high;
    ctrl.mode_select == `CTPWM_MODE_CMP && a_match && ctrl.output_function == `CTPWM_FN_HIGH |=> cmp_state;
  endproperty
  a_cmp_high: assert property (p_cmp_high) else $error("A match did not drive high");

  property p_cmp_low;
    ctrl.mode_select == `CTPWM_MODE_CMP && a_match && ctrl.output_function == `CTPWM_FN_LOW |=> !cmp_state;
  endproperty
  a_cmp_low: assert property (p_cmp_low) else $error("A match did not drive low");

  property p_cmp_toggle;
    ctrl.mode_select == `CTPWM_MODE_CMP && a_match && ctrl.output_function == `CTPWM_FN_TOGGLE
      |=> cmp_state != $past(cmp_state);
  endproperty
  a_cmp_toggle: assert property (p_cmp_toggle) else $error("A match did not toggle");

  c_pwm_period: cover property (pwm_mode && clr);
  c_cmp_toggle: cover property (ctrl.mode_select == `CTPWM_MODE_CMP && a_match
    && ctrl.output_function == `CTPWM_FN_TOGGLE);
  c_set_clear_race: cover property (set_a && w1c[`CTPWM_FLAG_A]);
  c_forced_count: cover property (pwm_mode && !ctrl.output_function[1] && clr);

endmodule // ctpwm_timer

// >>> shared/ctpwm_defs.svh
`ifndef CTPWM_DEFS_SVH
`define CTPWM_DEFS_SVH

// Register byte addresses
`define CTPWM_ADDR_CTRL0 4'h0
`define CTPWM_ADDR_CTRL1 4'h1
`define CTPWM_ADDR_CNT_LO 4'h2
`define CTPWM_ADDR_CNT_HI 4'h3
`define CTPWM_ADDR_CMPA_LO 4'h4
`define CTPWM_ADDR_CMPA_HI 4'h5
`define CTPWM_ADDR_STATUS 4'h6
`define CTPWM_ADDR_MASK 4'h7

// Reset values
`define CTPWM_RST_BYTE 8'h00
`define CTPWM_RST_CNT 10'h000
`define CTPWM_RST_FLAGS 2'h0
`define CTPWM_RST_PRESC 7'h00

// Control register 0 fields
`define CTPWM_RUN_BIT 0
`define CTPWM_CMPP_LSB 1
`define CTPWM_CMPP_MSB 3
`define CTPWM_DIV_LSB 4
`define CTPWM_DIV_MSB 6

// Mode select codes
`define CTPWM_MODE_CMP 2'h0
`define CTPWM_MODE_PWM 2'h2
`define CTPWM_MODE_TMR 2'h3

// Output function codes, compare match output mode
`define CTPWM_FN_NONE 2'h0
`define CTPWM_FN_LOW 2'h1
`define CTPWM_FN_HIGH 2'h2
`define CTPWM_FN_TOGGLE 2'h3

// Output function codes, PWM output mode (1x enables the waveform)
`define CTPWM_FN_FORCE_LO 2'h0
`define CTPWM_FN_FORCE_HI 2'h1

// Counter geometry
`define CTPWM_CNT_FULL 11'h400
`define CTPWM_CNT_MAX 10'h3ff
`define CTPWM_CNT_ONE 11'h001
`define CTPWM_CMPP_SHIFT 7

// Status and mask bit positions
`define CTPWM_FLAG_A 0
`define CTPWM_FLAG_P 1

`endif

// >>> shared/ctpwm_pkg.sv
package ctpwm_pkg;

  // Layout of control register 1
  typedef struct packed {
    logic [1:0] mode_select;
    logic [1:0] output_function;
    logic output_level_select;
    logic output_invert;
    logic period_duty_swap;
    logic clear_source_select;
  } ctpwm_ctrl_t;

  // One register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ctpwm_req_t;

  // Timer output pin
  typedef struct packed {
    logic level;
    logic oe_n;
  } ctpwm_pin_t;

endpackage

// >>> dv/compact_timer_pwm_modes_tb_top.sv
`timescale 1ns/1ns

module compact_timer_pwm_modes_tb_top;
  import ctpwm_pkg::*;

  logic clk;
  logic reset;
  ctpwm_req_t bus_req;
  logic [7:0] rdata;
  ctpwm_pin_t timer_pin;
  logic irq;
  int error_cnt;
  int n_compared;
  int cyc;
  logic [7:0] d;
  int c;

  ctpwm_timer dut (
    .clk(clk),
    .reset(reset),
    .bus_req(bus_req),
    .rdata(rdata),
    .timer_pin(timer_pin),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Run length is about 14k cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Requests start one edge after the previous one released, so no signal is driven twice in a step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask

  // Stops the timer first so no flag can be set while status is cleared
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p);
    wr(4'h0, 8'h00);
    wr(4'h6, 8'hff);
    wr(4'h1, c1);
    wr(4'h4, a[7:0]);
    wr(4'h5, {6'h00, a[9:8]});
    wr(4'h0, {4'h0, p, 1'b1});
  endtask

  task automatic cnt_hi(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(negedge clk);
      if (timer_pin.level === 1'b1) hi++;
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  typedef struct {
    logic [7:0] c1;
    logic [9:0] a;
    logic [2:0] p;
    int win;
    int hi;
  } ctpwm_case_t;

  ctpwm_case_t pwm_tab[8];

  initial begin
    reset = 1'b1;
    bus_req = '0;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    pwm_tab[0] = '{8'ha8, 10'd64, 3'd1, 128, 64};
    pwm_tab[1] = '{8'ha8, 10'd200, 3'd1, 128, 128};
    pwm_tab[2] = '{8'hac, 10'd32, 3'd1, 128, 96};
    pwm_tab[3] = '{8'ha0, 10'd32, 3'd1, 128, 96};
    pwm_tab[4] = '{8'ha8, 10'd256, 3'd0, 1024, 256};
    pwm_tab[5] = '{8'hab, 10'd200, 3'd1, 200, 128};
    pwm_tab[6] = '{8'h88, 10'd64, 3'd1, 128, 0};
    pwm_tab[7] = '{8'h98, 10'd64, 3'd1, 128, 128};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_chk(i[3:0], 8'h00);
    end
    wr(4'h8, 8'hff);
    rd_chk(4'h8, 8'h00);
    wr(4'h1, 8'hac);
    rd_chk(4'h1, 8'hac);
    // Compare mode, every output function; P period 128 so one A match in the first 20 cycles
    for (int f = 0; f < 4; f++) begin
      cfg({2'b00, f[1:0], (f < 2) ? 1'b1 : 1'b0, 3'b000}, 10'd5, 3'd1);
      wait_n(3);
      chk(timer_pin.level, (f < 2) ? 1'b1 : 1'b0);
      chk(timer_pin.oe_n, 1'b0);
      wait_n(20);
      chk(timer_pin.level, (f == 1) ? 1'b0 : 1'b1);
      rd_chk(4'h6, 8'h01);
    end
    cfg(8'h30, 10'd1000, 3'd1);
    wait_n(300);
    chk(timer_pin.level, 1'b0);
    rd_chk(4'h6, 8'h02);
    // A above the P target, so P matches happen but must not flag; counter wraps at 200
    cfg(8'h31, 10'd200, 3'd1);
    wait_n(300);
    rd_chk(4'h6, 8'h01);
    // Sampled 301 ticks after the run edge: 301 mod 200
    rd(4'h2, d);
    chk({8'h00, d}, 16'h0065);
    cfg(8'h31, 10'd0, 3'd1);
    wait_n(1100);
    rd_chk(4'h6, 8'h00);
    cfg(8'hc0, 10'd5, 3'd0);
    wait_n(1100);
    chk(timer_pin.oe_n, 1'b1);
    rd_chk(4'h6, 8'h03);
    wr(4'h0, 8'h00);
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h3, 8'h00);
    wr(4'h7, 8'h01);
    wait_n(2);
    chk(irq, 1'b1);
    wr(4'h7, 8'h00);
    wait_n(2);
    chk(irq, 1'b0);
    wr(4'h7, 8'h02);
    rd_chk(4'h7, 8'h02);
    wr(4'h6, 8'h02);
    wait_n(2);
    chk(irq, 1'b0);
    rd_chk(4'h6, 8'h01);
    wr(4'h7, 8'h00);
    // Steady state reached before counting, so any window of one period holds the duty exactly
    for (int i = 0; i < 8; i++) begin
      cfg(pwm_tab[i].c1, pwm_tab[i].a, pwm_tab[i].p);
      wait_n(1100);
      cnt_hi(pwm_tab[i].win, c);
      chk(c[15:0], pwm_tab[i].hi[15:0]);
      chk(timer_pin.oe_n, 1'b0);
    end
    rd_chk(4'h6, 8'h03);
    // Divider 2 ticks every fourth clock: nine ticks by the read sample
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h23);
    wait_n(40);
    rd_chk(4'h2, 8'h09);
    tally_and_finish();
  end
endmodule // compact_timer_pwm_modes_tb_top
